/* design/dst_channel.sv */
// dst_channel: one 16-bit timer with prescaler, edge count, edge time, pwm
// assumes: pin input may be asynchronous to ref_clk, two-flop synchronised here, registers come in as ports
`timescale 1ns/1ps
module dst_channel (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic active,
  input wire logic [1:0] mode,
  input wire logic cap_mode,
  input wire logic alt_mode,
  input wire logic enable_set,
  input wire logic enable_clr,
  input wire logic stall_en,
  input wire logic stall,
  input wire logic trig_en,
  input wire logic pwm_inv,
  input wire logic [1:0] event_sel,
  input wire logic load_we,
  input wire logic [15:0] load_wdata,
  input wire logic pre_we,
  input wire logic [7:0] pre_wdata,
  input wire logic match_we,
  input wire logic [15:0] match_wdata,
  input wire logic [2:0] int_clr,
  input wire logic [2:0] int_mask,
  input wire logic pin_in,
  output logic enabled,
  output logic [15:0] count,
  output logic [15:0] value,
  output logic [2:0] raw_flags,
  output logic [2:0] masked_flags,
  output logic trigger,
  output logic pwm_out,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic en_ff;
  logic [15:0] cnt_ff;
  logic [15:0] load_ff;
  logic [7:0] pre_ff;
  logic [7:0] pre_cnt_ff;
  logic [15:0] match_ff;
  logic [15:0] cap_ff;
  logic [2:0] raw_ff;
  logic trig_ff;
  logic pwm_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic ld_pend_ff;
  logic is_timer;
  logic is_pwm;
  logic is_ecount;
  logic is_etime;
  logic rise;
  logic fall;
  logic edge_hit;
  logic run;
  logic tick;
  logic at_zero;
  logic timeout;
  logic ec_match;
  logic capture;

  // mode decode
  assign is_pwm = active && alt_mode && !cap_mode && mode == dst_pkg::DST_MODE_PERIODIC;
  assign is_timer = active && !alt_mode && (mode == dst_pkg::DST_MODE_ONESHOT ||
                    mode == dst_pkg::DST_MODE_PERIODIC);
  assign is_ecount = active && !alt_mode && mode == dst_pkg::DST_MODE_CAPTURE && !cap_mode;
  assign is_etime = active && !alt_mode && mode == dst_pkg::DST_MODE_CAPTURE && cap_mode;

  // ----------------------------------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign rise = sync2_ff && !prev_ff;
  assign fall = !sync2_ff && prev_ff;
  // edge time never takes both edges
  always_comb begin
    edge_hit = 1'b0;
    unique case (event_sel)
      dst_pkg::DST_EVT_RISE: edge_hit = rise;
      dst_pkg::DST_EVT_FALL: edge_hit = fall;
      dst_pkg::DST_EVT_BOTH: edge_hit = is_etime ? rise : (rise || fall);
      default: edge_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  assign run = en_ff && !(stall_en && stall);
  assign at_zero = cnt_ff == dst_pkg::DST_ZERO;
  // prescaler only for one-shot and periodic
  assign tick = is_timer ? (pre_cnt_ff == dst_pkg::DST_PRE_ZERO) : 1'b1;
  assign timeout = run && is_timer && at_zero && tick;
  assign ec_match = run && is_ecount && edge_hit && (cnt_ff - dst_pkg::DST_ONE) == match_ff;
  assign capture = run && is_etime && edge_hit;

  // software registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_ff <= dst_pkg::DST_LOAD_RST;
      pre_ff <= dst_pkg::DST_PRE_RST;
      match_ff <= dst_pkg::DST_ZERO;
    end else begin
      if (load_we) load_ff <= load_wdata;
      if (pre_we) pre_ff <= pre_wdata;
      if (match_we) match_ff <= match_wdata;
    end
  end

  // enable bit: hardware clears on one-shot timeout or count match
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_ff <= 1'b0;
    end else if (enable_set && !enable_clr) begin
      en_ff <= 1'b1;
    end else if (enable_clr) begin
      en_ff <= 1'b0;
    end else if ((timeout && mode == dst_pkg::DST_MODE_ONESHOT) || ec_match) begin
      en_ff <= 1'b0;
    end
  end

  // a load written while running is taken one cycle later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ld_pend_ff <= 1'b0;
    end else begin
      ld_pend_ff <= load_we && en_ff;
    end
  end

  // main down-counter and prescaler
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff <= dst_pkg::DST_CNT_RST;
      pre_cnt_ff <= dst_pkg::DST_PRE_RST;
    end else if (ld_pend_ff) begin
      cnt_ff <= load_ff;
      pre_cnt_ff <= is_timer ? pre_ff : dst_pkg::DST_PRE_ZERO;
    end else if (!en_ff) begin
      if (load_we) begin
        cnt_ff <= load_wdata;
        pre_cnt_ff <= pre_ff;
      end
      if (pre_we) pre_cnt_ff <= pre_wdata;
    end else if (run && (is_timer || is_ecount || is_etime || is_pwm)) begin
      if (is_ecount) begin
        if (ec_match) begin
          cnt_ff <= load_ff;
        end else if (edge_hit) begin
          cnt_ff <= cnt_ff - dst_pkg::DST_ONE;
        end
      end else if (!tick) begin
        pre_cnt_ff <= pre_cnt_ff - dst_pkg::DST_PRE_ONE;
      end else if (at_zero) begin
        cnt_ff <= load_ff;
        pre_cnt_ff <= is_timer ? pre_ff : dst_pkg::DST_PRE_ZERO;
      end else begin
        cnt_ff <= cnt_ff - dst_pkg::DST_ONE;
        pre_cnt_ff <= is_timer ? pre_ff : dst_pkg::DST_PRE_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // capture, flags, trigger, pwm
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cap_ff <= dst_pkg::DST_CNT_RST;
    end else if (capture) begin
      cap_ff <= cnt_ff;
    end
  end

  // flags: bit0 timeout, bit1 match, bit2 capture; set wins over clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      raw_ff <= 3'h0;
    end else begin
      raw_ff[0] <= timeout || (raw_ff[0] && !int_clr[0]);
      raw_ff[1] <= ec_match || (raw_ff[1] && !int_clr[1]);
      raw_ff[2] <= capture || (raw_ff[2] && !int_clr[2]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= timeout && trig_en;
    end
  end

  // pwm level: set at load value, cleared at match; no flags raised
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwm_ff <= 1'b0;
    end else if (is_pwm && en_ff) begin
      if (cnt_ff == load_ff) pwm_ff <= 1'b1;
      else if (cnt_ff == match_ff) pwm_ff <= 1'b0;
    end else begin
      pwm_ff <= 1'b0;
    end
  end

  assign enabled = en_ff;
  assign count = cnt_ff;
  assign value = is_etime ? cap_ff : cnt_ff;
  assign raw_flags = raw_ff;
  assign masked_flags = raw_ff & int_mask;
  assign irq = |(raw_ff & int_mask);
  assign trigger = trig_ff;
  assign pwm_out = pwm_ff ^ pwm_inv;
endmodule // dst_channel

/* design/dst_pkg.sv */
// dst_pkg: constants shared by the dual 16-bit timer block and its channel
// assumes: single system clock, synchronous active-high reset
package dst_pkg;
  // ----------------------------------------------------------------
  // configuration and mode encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] DST_CFG_SPLIT16 = 3'h4;
  localparam logic [1:0] DST_MODE_ONESHOT = 2'h1;
  localparam logic [1:0] DST_MODE_PERIODIC = 2'h2;
  localparam logic [1:0] DST_MODE_CAPTURE = 2'h3;
  localparam logic [1:0] DST_EVT_RISE = 2'h0;
  localparam logic [1:0] DST_EVT_FALL = 2'h1;
  localparam logic [1:0] DST_EVT_BOTH = 2'h3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] DST_CNT_RST = 16'hFFFF;
  localparam logic [15:0] DST_LOAD_RST = 16'hFFFF;
  localparam logic [7:0] DST_PRE_RST = 8'h00;
  localparam logic [15:0] DST_ZERO = 16'h0000;
  localparam logic [15:0] DST_ONE = 16'h0001;
  localparam logic [7:0] DST_PRE_ONE = 8'h01;
  localparam logic [7:0] DST_PRE_ZERO = 8'h00;
endpackage

/* design/dst_top.sv */
// dst_top: general timer block, two 16-bit timers in split mode
// assumes: register fields arrive as plain ports, writes are one-cycle strobes
`timescale 1ns/1ps
// What this block does
// - block config value 0x4 runs both timers independently in 16-bit modes
// - one-shot/periodic is 16-bit down-counter with optional 8-bit prescaler
// - enable starts countdown; after zero reload interval and prescale values
// - one-shot timeout stops and clears enable; periodic keeps running
// - timeout sets raw flag, held until interrupt clear written
// - unmasked timeout also sets masked flag and interrupt request
// - trigger pulse on timeout only with output trigger enable set
// - interval load write while running taken next cycle, counting continues
// - stall enable with stall asserted freezes count until released
// - prescale p gives p+1 clocks per decrement
// - prescaler bypassed in edge count, edge time and pwm modes
// - capture-mode bit zero counts edges; event field picks edge type
// - each edge decrements; match sets raw and masked match flags
// - on match reload, clear enable, ignore edges until re-enabled
// - capture-mode bit selects edge time; one edge type, starts 0xFFFF
// - selected edge copies count to value register, sets capture flags
// - edge time counter keeps running, reloads after zero
// - pwm selected by alternate bit 1, capture bit 0, mode 0x2
// - pwm counts to zero, reloads, repeats, raises no flags
// - pwm output sets at load value, clears at match, invert option
// - mode field: one-shot 0x1, periodic 0x2, capture 0x3
// - reset gives counters and loads 0xFFFF, prescalers 0x00
module dst_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] block_config_reg,
  input wire logic [1:0] a_timer_mode_field,
  input wire logic a_capture_mode_bit,
  input wire logic a_alternate_mode_select,
  input wire logic a_enable_set,
  input wire logic a_enable_clr,
  input wire logic a_stall_enable_bit,
  input wire logic a_output_trigger_enable,
  input wire logic a_pwm_output_invert,
  input wire logic [1:0] a_event_sel,
  input wire logic a_load_we,
  input wire logic [15:0] a_load_wdata,
  input wire logic a_pre_we,
  input wire logic [7:0] a_pre_wdata,
  input wire logic a_match_we,
  input wire logic [15:0] a_match_wdata,
  input wire logic [2:0] a_int_clr,
  input wire logic [2:0] a_int_mask,
  input wire logic a_capture_compare_pin_in,
  output logic a_timer_enable_bit,
  output logic [15:0] a_count,
  output logic [15:0] a_timer_value_reg,
  output logic [2:0] a_raw_status,
  output logic [2:0] a_masked_status,
  output logic a_trigger,
  output logic a_pwm_out,
  input wire logic [1:0] b_timer_mode_field,
  input wire logic b_capture_mode_bit,
  input wire logic b_alternate_mode_select,
  input wire logic b_enable_set,
  input wire logic b_enable_clr,
  input wire logic b_stall_enable_bit,
  input wire logic b_output_trigger_enable,
  input wire logic b_pwm_output_invert,
  input wire logic [1:0] b_event_sel,
  input wire logic b_load_we,
  input wire logic [15:0] b_load_wdata,
  input wire logic b_pre_we,
  input wire logic [7:0] b_pre_wdata,
  input wire logic b_match_we,
  input wire logic [15:0] b_match_wdata,
  input wire logic [2:0] b_int_clr,
  input wire logic [2:0] b_int_mask,
  input wire logic b_capture_compare_pin_in,
  output logic b_timer_enable_bit,
  output logic [15:0] b_count,
  output logic [15:0] b_timer_value_reg,
  output logic [2:0] b_raw_status,
  output logic [2:0] b_masked_status,
  output logic b_trigger,
  output logic b_pwm_out,
  input wire logic stall,
  output logic irq
);
  // ----------------------------------------------------------------
  // split mode decode
  // ----------------------------------------------------------------
  logic split;
  logic irq_a;
  logic irq_b;

  assign split = block_config_reg == dst_pkg::DST_CFG_SPLIT16;

  // timer a
  dst_channel u_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .active(split),
    .mode(a_timer_mode_field),
    .cap_mode(a_capture_mode_bit),
    .alt_mode(a_alternate_mode_select),
    .enable_set(a_enable_set),
    .enable_clr(a_enable_clr),
    .stall_en(a_stall_enable_bit),
    .stall(stall),
    .trig_en(a_output_trigger_enable),
    .pwm_inv(a_pwm_output_invert),
    .event_sel(a_event_sel),
    .load_we(a_load_we),
    .load_wdata(a_load_wdata),
    .pre_we(a_pre_we),
    .pre_wdata(a_pre_wdata),
    .match_we(a_match_we),
    .match_wdata(a_match_wdata),
    .int_clr(a_int_clr),
    .int_mask(a_int_mask),
    .pin_in(a_capture_compare_pin_in),
    .enabled(a_timer_enable_bit),
    .count(a_count),
    .value(a_timer_value_reg),
    .raw_flags(a_raw_status),
    .masked_flags(a_masked_status),
    .trigger(a_trigger),
    .pwm_out(a_pwm_out),
    .irq(irq_a)
  );

  // timer b
  dst_channel u_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .active(split),
    .mode(b_timer_mode_field),
    .cap_mode(b_capture_mode_bit),
    .alt_mode(b_alternate_mode_select),
    .enable_set(b_enable_set),
    .enable_clr(b_enable_clr),
    .stall_en(b_stall_enable_bit),
    .stall(stall),
    .trig_en(b_output_trigger_enable),
    .pwm_inv(b_pwm_output_invert),
    .event_sel(b_event_sel),
    .load_we(b_load_we),
    .load_wdata(b_load_wdata),
    .pre_we(b_pre_we),
    .pre_wdata(b_pre_wdata),
    .match_we(b_match_we),
    .match_wdata(b_match_wdata),
    .int_clr(b_int_clr),
    .int_mask(b_int_mask),
    .pin_in(b_capture_compare_pin_in),
    .enabled(b_timer_enable_bit),
    .count(b_count),
    .value(b_timer_value_reg),
    .raw_flags(b_raw_status),
    .masked_flags(b_masked_status),
    .trigger(b_trigger),
    .pwm_out(b_pwm_out),
    .irq(irq_b)
  );

  assign irq = irq_a || irq_b;
endmodule // dst_top

/* verification/dst_checker.sv */
// dst_checker: port assertions on timer a of the dual timer block
// assumes: bound to dst_top, one clock, synchronous active-high reset
`timescale 1ns/1ps
module dst_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] a_timer_mode_field,
  input wire logic a_alternate_mode_select,
  input wire logic a_enable_set,
  input wire logic a_enable_clr,
  input wire logic a_stall_enable_bit,
  input wire logic a_output_trigger_enable,
  input wire logic a_load_we,
  input wire logic [2:0] a_int_clr,
  input wire logic [2:0] a_int_mask,
  input wire logic a_timer_enable_bit,
  input wire logic [15:0] a_count,
  input wire logic [2:0] a_raw_status,
  input wire logic [2:0] a_masked_status,
  input wire logic a_trigger,
  input wire logic stall,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_en_set;
    a_enable_set && !a_enable_clr && !a_timer_enable_bit |=> a_timer_enable_bit;
  endproperty
  property p_mask;
    a_masked_status == (a_raw_status & a_int_mask);
  endproperty
  property p_irq;
    |a_masked_status |-> irq;
  endproperty
  property p_trig;
    a_trigger |-> a_raw_status[0] && $past(a_output_trigger_enable);
  endproperty
  property p_oneshot;
    a_trigger && a_timer_mode_field == 2'h1 |-> !a_timer_enable_bit;
  endproperty
  property p_stall;
    a_timer_enable_bit && a_stall_enable_bit && stall && !$past(a_load_we) |=> $stable(a_count);
  endproperty
  property p_hold;
    a_raw_status[0] && !a_int_clr[0] |=> a_raw_status[0];
  endproperty
  property p_pwm;
    a_alternate_mode_select && a_timer_mode_field == 2'h2 && a_raw_status == 3'h0
      |=> a_raw_status == 3'h0;
  endproperty
  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  a_en_set: assert property (p_en_set) else $error("enable not set");
  a_mask: assert property (p_mask) else $error("masked status wrong");
  a_irq: assert property (p_irq) else $error("irq missing");
  a_trig: assert property (p_trig) else $error("stray trigger");
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept enable");
  a_stall: assert property (p_stall) else $error("count moved in stall");
  a_hold: assert property (p_hold) else $error("timeout flag lost");
  a_pwm: assert property (p_pwm) else $error("flag raised in pwm");
  c_timeout: cover property (a_trigger);
  c_match: cover property ($rose(a_raw_status[1]));
  c_capture: cover property ($rose(a_raw_status[2]));
endmodule // dst_checker

bind dst_top dst_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .a_timer_mode_field(a_timer_mode_field),
  .a_alternate_mode_select(a_alternate_mode_select), .a_enable_set(a_enable_set),
  .a_enable_clr(a_enable_clr), .a_stall_enable_bit(a_stall_enable_bit),
  .a_output_trigger_enable(a_output_trigger_enable), .a_load_we(a_load_we),
  .a_int_clr(a_int_clr), .a_int_mask(a_int_mask), .a_timer_enable_bit(a_timer_enable_bit),
  .a_count(a_count), .a_raw_status(a_raw_status), .a_masked_status(a_masked_status),
  .a_trigger(a_trigger), .stall(stall), .irq(irq)
);

/* verification/dst_pin_src.sv */
// dst_pin_src: external source on the capture/compare pin
// assumes: bench calls drive at its own pace, one system clock
`timescale 1ns/1ps
module dst_pin_src (
  input wire logic ref_clk,
  output logic pin
);
  initial pin = 1'b0;
  // new level after a falling edge, held two clocks or more
  task automatic drive(input logic lvl, input int hold);
    @(negedge ref_clk);
    pin = lvl;
    repeat (hold < 2 ? 2 : hold) @(negedge ref_clk);
  endtask
endmodule // dst_pin_src

/* verification/dst_top_tb.sv */
// dst_top_tb: self-checking bench for the dual 16-bit timer block
// assumes: checker bound to dst_top, both timers share one set of inputs
`timescale 1ns/1ps
module dst_top_tb;
  logic ref_clk = 1'b0, rst = 1'b1, cap = 1'b0, alt = 1'b0, es = 1'b0, ec = 1'b0, se = 1'b0;
  logic ote = 1'b0, inv = 1'b0, lwe = 1'b0, pwe = 1'b0, mwe = 1'b0, stl = 1'b0;
  logic [2:0] cfg = 3'h4, ic = 3'h0, im = 3'h0;
  logic [1:0] md = 2'h0, ev = 2'h0;
  logic [15:0] ld = 16'h0000, mt = 16'h0000, v;
  logic [7:0] pd = 8'h00;
  logic pin, a_en, b_en, a_trg, b_trg, a_pwm, b_pwm, irq;
  logic [15:0] a_cnt, b_cnt, a_val, b_val;
  logic [2:0] a_raw, b_raw, a_msk, b_msk;
  int failures = 0, comparisons = 0, n;
  // ----------------------------------------------------------------
  // clock, source model and design
  // ----------------------------------------------------------------
  initial forever #2 ref_clk = ~ref_clk;
  dst_pin_src src (.ref_clk(ref_clk), .pin(pin));
  dst_top dut (
    .ref_clk(ref_clk), .rst(rst), .block_config_reg(cfg), .stall(stl), .irq(irq),
    .a_timer_mode_field(md), .a_capture_mode_bit(cap), .a_alternate_mode_select(alt),
    .a_enable_set(es), .a_enable_clr(ec), .a_stall_enable_bit(se),
    .a_output_trigger_enable(ote), .a_pwm_output_invert(inv), .a_event_sel(ev),
    .a_load_we(lwe), .a_load_wdata(ld), .a_pre_we(pwe), .a_pre_wdata(pd), .a_match_we(mwe),
    .a_match_wdata(mt), .a_int_clr(ic), .a_int_mask(im), .a_capture_compare_pin_in(pin),
    .a_timer_enable_bit(a_en), .a_count(a_cnt), .a_timer_value_reg(a_val),
    .a_raw_status(a_raw), .a_masked_status(a_msk), .a_trigger(a_trg), .a_pwm_out(a_pwm),
    .b_timer_mode_field(md), .b_capture_mode_bit(cap), .b_alternate_mode_select(alt),
    .b_enable_set(es), .b_enable_clr(ec), .b_stall_enable_bit(se),
    .b_output_trigger_enable(ote), .b_pwm_output_invert(inv), .b_event_sel(ev),
    .b_load_we(lwe), .b_load_wdata(ld), .b_pre_we(pwe), .b_pre_wdata(pd), .b_match_we(mwe),
    .b_match_wdata(mt), .b_int_clr(ic), .b_int_mask(im), .b_capture_compare_pin_in(pin),
    .b_timer_enable_bit(b_en), .b_count(b_cnt), .b_timer_value_reg(b_val),
    .b_raw_status(b_raw), .b_masked_status(b_msk), .b_trigger(b_trg), .b_pwm_out(b_pwm)
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic clr;
    ic = 3'h7;
    tick(1);
    ic = 3'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_raw(input int b);
    n = 0;
    while (a_raw[b] !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200) begin
      failures++;
      test_done;
    end
  endtask
  task test_done;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_cfg;
    chk({a_en, a_raw, a_pwm}, 16'h0000);
    chk(a_cnt, 16'hFFFF);
    cfg = 3'h0;
    md = 2'h2;
    pulse(es);
    tick(3);
    chk(a_cnt, 16'hFFFF);
    pulse(ec);
    cfg = 3'h4;
  endtask
  task automatic s_periodic;
    ote = 1'b1;
    im = 3'h1;
    ld = 16'h0002;
    pulse(lwe);
    pulse(es);
    chk({a_en, a_cnt}, 17'h10002);
    tick(2);
    chk(a_cnt, 16'h0000);
    tick(1);
    chk({a_raw, a_msk, a_trg, irq, a_cnt}, 24'h270002);
    chk({b_en, b_raw, b_msk, b_trg, b_cnt}, 24'h930002);
    tick(1);
    chk({a_trg, a_raw}, 4'h1);
    clr;
    chk(a_raw, 3'h0);
    ote = 1'b0;
    tick(1);
    chk({a_trg, a_raw[0], a_cnt}, 18'h10002);
    se = 1'b1;
    stl = 1'b1;
    tick(3);
    chk(a_cnt, 16'h0002);
    stl = 1'b0;
    tick(1);
    chk(a_cnt, 16'h0001);
    se = 1'b0;
    ld = 16'h0005;
    pulse(lwe);
    tick(1);
    chk(a_cnt, 16'h0005);
    tick(1);
    chk(a_cnt, 16'h0004);
    pulse(ec);
    clr;
  endtask
  task automatic s_prescale;
    md = 2'h1;
    ote = 1'b1;
    pd = 8'h02;
    pulse(pwe);
    ld = 16'h0001;
    pulse(lwe);
    pulse(es);
    wait_raw(0);
    chk(n[15:0], 16'h0006);
    chk({a_en, a_trg, a_cnt}, 18'h10001);
    clr;
    pd = 8'h00;
    pulse(pwe);
  endtask
  task automatic s_edge_count;
    md = 2'h3;
    ev = 2'h3;
    im = 3'h2;
    pd = 8'h03;
    pulse(pwe);
    ld = 16'h000A;
    pulse(lwe);
    mt = 16'h0006;
    pulse(mwe);
    pulse(es);
    repeat (2) src.drive(!pin, 4);
    chk(a_cnt, 16'h0008);
    repeat (2) src.drive(!pin, 4);
    chk({a_en, a_raw, a_msk, a_cnt}, 23'h12000A);
    repeat (2) src.drive(!pin, 4);
    chk({a_en, a_cnt}, 17'h0000A);
    clr;
    for (int e = 0; e < 2; e++) begin
      ev = e[1:0];
      pulse(lwe);
      pulse(es);
      repeat (4) src.drive(!pin, 4);
      chk(a_cnt, 16'h0008);
      pulse(ec);
    end
  endtask
  task automatic s_edge_time;
    cap = 1'b1;
    ev = 2'h0;
    im = 3'h4;
    ld = 16'hFFFF;
    pulse(lwe);
    pulse(es);
    tick(5);
    src.drive(1'b1, 1);
    wait_raw(2);
    chk({15'h0000, 16'(a_val - a_cnt) <= 16'h0002}, 16'h0001);
    chk(a_msk, 3'h4);
    chk({b_msk, 16'(b_val - b_cnt)}, 19'h40001);
    v = a_val;
    src.drive(1'b0, 6);
    chk(a_val, v);
    chk({15'h0000, a_cnt !== v}, 16'h0001);
    src.drive(1'b1, 6);
    chk({15'h0000, a_val !== v}, 16'h0001);
    pulse(ec);
    clr;
  endtask
  task automatic s_pwm;
    md = 2'h2;
    cap = 1'b0;
    alt = 1'b1;
    ld = 16'h0004;
    pulse(lwe);
    mt = 16'h0002;
    pulse(mwe);
    pulse(es);
    tick(6);
    for (int k = 0; k < 2; k++) begin
      inv = k[0];
      tick(2);
      n = 0;
      repeat (10) begin
        tick(1);
        n += int'(a_pwm === 1'b1) + int'(b_pwm === 1'b1);
      end
      chk(n[15:0], k ? 16'h000C : 16'h0008);
    end
    chk(a_raw, 3'h0);
    pulse(ec);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    tick(1);
    s_cfg;
    s_periodic;
    s_prescale;
    s_edge_count;
    s_edge_time;
    s_pwm;
    test_done;
  end
  initial begin
    #100000;
    failures++;
    test_done;
  end
endmodule // dst_top_tb
